/* File: rtl/rgt_consts.svh */
// Register offsets, field positions, reset values and timing counts for the gain and power block
`ifndef RGT_CONSTS_SVH
`define RGT_CONSTS_SVH

// Register addresses on the serial register port
`define RGT_ADDR_STATE 6'h02
`define RGT_ADDR_TX_POWER_LEVEL 6'h05
`define RGT_ADDR_TX_TIME 6'h3b
`define RGT_ADDR_GAIN_TEST 6'h3c

// Field positions
`define RGT_TXP_LSB 0
`define RGT_TXP_MSB 3
`define RGT_GT_GAIN_LSB 0
`define RGT_GT_GAIN_MSB 1
`define RGT_GT_FREEZE 2
`define RGT_GT_AUTO_OFF 3
`define RGT_GT_LOOP_RST 4
`define RGT_GT_FREEZE_SEL 5
`define RGT_CMD_MSB 4

// Reset values
`define RGT_TX_POWER_LEVEL_RST 4'h0
`define RGT_GAIN_TEST_RST 6'h00
`define RGT_GAIN_MAX 2'h0
`define RGT_GAIN_RESERVED 2'h3

// State commands
`define RGT_CMD_TX_START 5'h02
`define RGT_CMD_TRX_OFF 5'h08
`define RGT_CMD_PLL_ON 5'h09
`define RGT_CMD_ARET_ON 5'h19

// Timing at a 4 ns clock
`define RGT_CLK_PERIOD_NS 4
`define RGT_MOD_DELAY_NS 16000
`define RGT_PA_DELAY_NS 2000
`define RGT_MOD_CYC ((`RGT_MOD_DELAY_NS + `RGT_CLK_PERIOD_NS - 1) / `RGT_CLK_PERIOD_NS)
`define RGT_PA_CYC ((`RGT_PA_DELAY_NS + `RGT_CLK_PERIOD_NS - 1) / `RGT_CLK_PERIOD_NS)
`define RGT_CLOCK_OUTPUT_PIN_PERIOD_NS 1000
`define RGT_CLOCK_OUTPUT_PIN_CYC (`RGT_CLOCK_OUTPUT_PIN_PERIOD_NS / `RGT_CLK_PERIOD_NS)
`define RGT_ALIGN_STEPS 16

`endif

/* File: rtl/rgt_pkg.sv */
// Types shared by the gain and transmit power block
`default_nettype none
package rgt_pkg;
  typedef enum logic [2:0] {
    RGT_ST_OFF = 3'b000,
    RGT_ST_PLL = 3'b001,
    RGT_ST_ARET = 3'b010,
    RGT_ST_BUSY = 3'b011,
    RGT_ST_BUSY_ARET = 3'b100
  } rgt_state_type;
endpackage : rgt_pkg
`default_nettype wire

/* File: rtl/rgt_tx_ramp.sv */
// Transmit start sequencer: amplifier buffer, amplifier, then modulation
`include "rgt_consts.svh"
`default_nettype none
module rgt_tx_ramp
  import rgt_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // Control
  input wire logic start,
  input wire logic stop,
  // Front-end enables
  output logic pa_buf_en_q,
  output logic pa_en_q,
  output logic modulate_q
);

  localparam logic [11:0] MOD_LAST = 12'(`RGT_MOD_CYC - 1);
  localparam logic [11:0] PA_LAST = 12'(`RGT_PA_CYC - 1);

  logic [11:0] cnt_q;
  logic [11:0] cnt_d;
  logic run_q;
  logic run_d;
  logic pa_buf_en_d;
  logic pa_en_d;
  logic modulate_d;

  always_comb begin
    cnt_d = cnt_q;
    run_d = run_q;
    pa_buf_en_d = pa_buf_en_q;
    pa_en_d = pa_en_q;
    modulate_d = modulate_q;
    if (stop) begin
      run_d = 1'b0;
      cnt_d = 12'h000;
      pa_buf_en_d = 1'b0;
      pa_en_d = 1'b0;
      modulate_d = 1'b0;
    end else if (start && !run_q) begin
      // Buffer first, amplifier later, to keep the spectrum clean
      run_d = 1'b1;
      cnt_d = 12'h000;
      pa_buf_en_d = 1'b1;
    end else if (run_q && !modulate_q) begin
      cnt_d = cnt_q + 12'h001;
      if (cnt_q == PA_LAST) begin
        pa_en_d = 1'b1;
      end
      // Start pulse arrives one cycle after the pin edge
      if (cnt_q == MOD_LAST - 12'h001) begin
        modulate_d = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q <= 12'h000;
      run_q <= 1'b0;
      pa_buf_en_q <= 1'b0;
      pa_en_q <= 1'b0;
      modulate_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      run_q <= run_d;
      pa_buf_en_q <= pa_buf_en_d;
      pa_en_q <= pa_en_d;
      modulate_q <= modulate_d;
    end
  end

endmodule : rgt_tx_ramp
`default_nettype wire

/* File: rtl/rgt_gain_power.sv */
// Receiver gain control, transmit power, transmit start and timing readback
//
// Summary of operation
// - Auto-gain-disable set stops automatic gain regulation and applies manual gain.
// - Gain-loop-freeze 0 lets the gain loop run; 1 freezes it.
// - Manual gain field reaches the receive path only while auto gain is off.
// - Manual gain codes: 0 maximum, 1 medium, 2 minimum, 3 reserved.
// - Transmit starts from PLL idle or retry-ready on pin rise or start command.
// - Transmit trigger in PLL idle moves the device to busy transmit.
// - Modulation begins 16 us after the trigger pin rising edge.
// - Amplifier buffer is enabled before the amplifier, never together.
// - Four-bit power code picks sixteen levels, 0 highest, 15 lowest.
// - A state command write restores the programmed transmit power unless a frame ends in the same cycle.
// - With reduced-power control in extended mode, power reads return last used.
// - Reduced-power value shows only after one frame was sent.
// - In time measure mode with phase measure mode off, timing register gives 4-bit alignment, upper bits zero.
// - In phase measure mode timing register gives the 8-bit phase value.
// - Gain test fields always read/write; act only with phase enable set.
// - Freeze select 1 takes the freeze bit; 0 means normal operation.
// - Alignment counts trigger-to-clock-output offset in sixteenths of a microsecond.
`include "rgt_consts.svh"
`default_nettype none
module rgt_gain_power
  import rgt_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // Register port
  input wire logic [5:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata_q,
  // Mode inputs
  input wire logic phase_measure_enable,
  input wire logic time_measure_mode,
  input wire logic phase_measure_mode,
  input wire logic ext_mode,
  input wire logic reduced_power_tx_enable,
  // Measurement and controller inputs
  input wire logic [7:0] phase_value,
  input wire logic [3:0] rpc_power_level,
  input wire logic [1:0] auto_gain_target,
  // Transmit control
  input wire logic sleep_tx_trigger_pin,
  input wire logic tx_frame_done,
  // Receive path
  output logic [1:0] rx_gain_q,
  output logic gain_loop_frozen_q,
  output logic auto_gain_off_q,
  // Transmit path
  output logic [3:0] tx_power_level_q,
  output logic pa_buf_en_q,
  output logic pa_en_q,
  output logic modulate_q,
  output logic [2:0] state_control_reg_q,
  output logic clock_output_pin_q
);

  // Register write and read decode
  function automatic logic hit(input logic [5:0] addr, input logic [5:0] target);
    hit = (addr == target);
  endfunction : hit

  logic wr_pwr;
  logic wr_test;
  logic wr_state;
  assign wr_pwr = reg_wr && hit(reg_addr, `RGT_ADDR_TX_POWER_LEVEL);
  assign wr_test = reg_wr && hit(reg_addr, `RGT_ADDR_GAIN_TEST);
  assign wr_state = reg_wr && hit(reg_addr, `RGT_ADDR_STATE);

  // Software-held fields
  logic [3:0] tx_power_level_prog_q;
  logic [3:0] tx_power_level_prog_d;
  logic [5:0] gain_test_q;
  logic [5:0] gain_test_d;

  always_comb begin
    tx_power_level_prog_d = tx_power_level_prog_q;
    gain_test_d = gain_test_q;
    if (wr_pwr) begin
      tx_power_level_prog_d = reg_wdata[`RGT_TXP_MSB:`RGT_TXP_LSB];
    end
    if (wr_test) begin
      gain_test_d = reg_wdata[5:0];
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      tx_power_level_prog_q <= `RGT_TX_POWER_LEVEL_RST;
      gain_test_q <= `RGT_GAIN_TEST_RST;
    end else begin
      tx_power_level_prog_q <= tx_power_level_prog_d;
      gain_test_q <= gain_test_d;
    end
  end

  // Gain test fields act only with phase measurement enabled
  logic [5:0] gt_eff;
  assign gt_eff = phase_measure_enable ? gain_test_q : `RGT_GAIN_TEST_RST;

  logic auto_off;
  logic freeze;
  logic loop_rst;
  logic [1:0] manual_rx_gain;
  assign auto_off = gt_eff[`RGT_GT_AUTO_OFF];
  assign manual_rx_gain = gt_eff[`RGT_GT_GAIN_MSB:`RGT_GT_GAIN_LSB];
  assign loop_rst = gt_eff[`RGT_GT_LOOP_RST];
  // Freeze bit only counts when the select bit hands the loop to software
  assign freeze = gt_eff[`RGT_GT_FREEZE_SEL] && gt_eff[`RGT_GT_FREEZE];

  // Gain loop and receive gain output
  logic [1:0] gain_loop_q;
  logic [1:0] gain_loop_d;
  logic [1:0] rx_gain_d;
  logic gain_loop_frozen_d;
  logic auto_gain_off_d;

  always_comb begin
    gain_loop_d = gain_loop_q;
    if (loop_rst) begin
      gain_loop_d = `RGT_GAIN_MAX;
    end else if (!auto_off && !freeze) begin
      gain_loop_d = auto_gain_target;
    end
    rx_gain_d = gain_loop_q;
    if (auto_off) begin
      // Reserved code keeps the last applied gain rather than guessing a level
      if (manual_rx_gain != `RGT_GAIN_RESERVED) begin
        rx_gain_d = manual_rx_gain;
      end else begin
        rx_gain_d = rx_gain_q;
      end
    end
    gain_loop_frozen_d = freeze;
    auto_gain_off_d = auto_off;
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      gain_loop_q <= `RGT_GAIN_MAX;
      rx_gain_q <= `RGT_GAIN_MAX;
      gain_loop_frozen_q <= 1'b0;
      auto_gain_off_q <= 1'b0;
    end else begin
      gain_loop_q <= gain_loop_d;
      rx_gain_q <= rx_gain_d;
      gain_loop_frozen_q <= gain_loop_frozen_d;
      auto_gain_off_q <= auto_gain_off_d;
    end
  end

  // Trigger pin edge and state commands
  logic trig_q;
  logic trig_rise;
  logic [4:0] cmd;
  logic cmd_start;
  assign trig_rise = sleep_tx_trigger_pin && !trig_q;
  assign cmd = reg_wdata[`RGT_CMD_MSB:0];
  assign cmd_start = wr_state && (cmd == `RGT_CMD_TX_START);

  rgt_state_type state_q;
  rgt_state_type state_d;
  logic start_tx;

  always_comb begin
    state_d = state_q;
    start_tx = 1'b0;
    case (state_q)
      RGT_ST_PLL: begin
        if (trig_rise || cmd_start) begin
          state_d = RGT_ST_BUSY;
          start_tx = 1'b1;
        end else if (wr_state && cmd == `RGT_CMD_ARET_ON) begin
          state_d = RGT_ST_ARET;
        end else if (wr_state && cmd == `RGT_CMD_TRX_OFF) begin
          state_d = RGT_ST_OFF;
        end
      end
      RGT_ST_ARET: begin
        if (trig_rise || cmd_start) begin
          state_d = RGT_ST_BUSY_ARET;
          start_tx = 1'b1;
        end else if (wr_state && cmd == `RGT_CMD_PLL_ON) begin
          state_d = RGT_ST_PLL;
        end else if (wr_state && cmd == `RGT_CMD_TRX_OFF) begin
          state_d = RGT_ST_OFF;
        end
      end
      RGT_ST_BUSY: begin
        if (tx_frame_done) begin
          state_d = RGT_ST_PLL;
        end
      end
      RGT_ST_BUSY_ARET: begin
        if (tx_frame_done) begin
          state_d = RGT_ST_ARET;
        end
      end
      default: begin
        if (wr_state && cmd == `RGT_CMD_PLL_ON) begin
          state_d = RGT_ST_PLL;
        end else if (wr_state && cmd == `RGT_CMD_ARET_ON) begin
          state_d = RGT_ST_ARET;
        end
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      trig_q <= 1'b0;
      state_q <= RGT_ST_OFF;
      state_control_reg_q <= RGT_ST_OFF;
    end else begin
      trig_q <= sleep_tx_trigger_pin;
      state_q <= state_d;
      state_control_reg_q <= state_d;
    end
  end

  rgt_tx_ramp u_ramp (
    .mclk(mclk),
    .rst_b(rst_b),
    .start(start_tx),
    .stop(tx_frame_done),
    .pa_buf_en_q(pa_buf_en_q),
    .pa_en_q(pa_en_q),
    .modulate_q(modulate_q)
  );

  // Power used for the last frame under reduced-power control
  logic [3:0] tx_power_level_used_q;
  logic [3:0] tx_power_level_used_d;
  logic rpc_sent_q;
  logic rpc_sent_d;
  logic rpc_on;
  logic [3:0] tx_power_level_eff;
  logic [3:0] tx_power_level_d;
  assign rpc_on = ext_mode && reduced_power_tx_enable;
  assign tx_power_level_eff = (rpc_on && rpc_sent_q) ? tx_power_level_used_q : tx_power_level_prog_q;

  always_comb begin
    tx_power_level_used_d = tx_power_level_used_q;
    rpc_sent_d = rpc_sent_q;
    // A frame end in the same cycle as a command still records its power
    if (wr_state) begin
      rpc_sent_d = 1'b0;
    end
    if (tx_frame_done && rpc_on) begin
      tx_power_level_used_d = rpc_power_level;
      rpc_sent_d = 1'b1;
    end
    tx_power_level_d = tx_power_level_eff;
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      tx_power_level_used_q <= `RGT_TX_POWER_LEVEL_RST;
      rpc_sent_q <= 1'b0;
      tx_power_level_q <= `RGT_TX_POWER_LEVEL_RST;
    end else begin
      tx_power_level_used_q <= tx_power_level_used_d;
      rpc_sent_q <= rpc_sent_d;
      tx_power_level_q <= tx_power_level_d;
    end
  end

  // 1 MHz clock output and trigger alignment capture
  localparam logic [7:0] CLOCK_OUTPUT_PIN_LAST = 8'(`RGT_CLOCK_OUTPUT_PIN_CYC - 1);
  localparam logic [7:0] CLOCK_OUTPUT_PIN_HALF = 8'(`RGT_CLOCK_OUTPUT_PIN_CYC / 2);
  localparam logic [11:0] CLOCK_OUTPUT_PIN_CYC12 = 12'(`RGT_CLOCK_OUTPUT_PIN_CYC);
  localparam logic [11:0] STEPS12 = 12'(`RGT_ALIGN_STEPS);

  logic [7:0] clock_output_pin_cnt_q;
  logic [7:0] clock_output_pin_cnt_d;
  logic clock_output_pin_d;
  logic [3:0] align_q;
  logic [3:0] align_d;
  logic [11:0] align_full;
  // Edge is seen one cycle late, so the phase one cycle back is the true one
  logic [7:0] edge_phase;
  assign edge_phase = (clock_output_pin_cnt_q == 8'h00) ? CLOCK_OUTPUT_PIN_LAST : clock_output_pin_cnt_q - 8'h01;
  assign align_full = ({4'h0, edge_phase} * STEPS12) / CLOCK_OUTPUT_PIN_CYC12;

  always_comb begin
    clock_output_pin_cnt_d = (clock_output_pin_cnt_q == CLOCK_OUTPUT_PIN_LAST) ? 8'h00 : clock_output_pin_cnt_q + 8'h01;
    clock_output_pin_d = (clock_output_pin_cnt_d < CLOCK_OUTPUT_PIN_HALF);
    align_d = align_q;
    if (trig_rise) begin
      align_d = align_full[3:0];
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      clock_output_pin_cnt_q <= 8'h00;
      clock_output_pin_q <= 1'b0;
      align_q <= 4'h0;
    end else begin
      clock_output_pin_cnt_q <= clock_output_pin_cnt_d;
      clock_output_pin_q <= clock_output_pin_d;
      align_q <= align_d;
    end
  end

  // Read data
  logic [7:0] rdata_d;

  always_comb begin
    rdata_d = reg_rdata_q;
    if (reg_rd) begin
      if (hit(reg_addr, `RGT_ADDR_TX_POWER_LEVEL)) begin
        rdata_d = {4'h0, tx_power_level_eff};
      end else if (hit(reg_addr, `RGT_ADDR_TX_TIME)) begin
        if (phase_measure_mode) begin
          rdata_d = phase_value;
        end else if (time_measure_mode) begin
          rdata_d = {4'h0, align_q};
        end else begin
          rdata_d = 8'h00;
        end
      end else if (hit(reg_addr, `RGT_ADDR_GAIN_TEST)) begin
        rdata_d = {2'b00, gain_test_q};
      end else begin
        rdata_d = 8'h00;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata_q <= 8'h00;
    end else begin
      reg_rdata_q <= rdata_d;
    end
  end

endmodule : rgt_gain_power
`default_nettype wire

/* File: tb/rgt_gain_power_asserts.sv */
// Port-level checker for the gain and transmit power block
`default_nettype none
module rgt_gain_power_chk
  import rgt_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // Register port
  input wire logic [5:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata_q,
  // Modes and triggers
  input wire logic phase_measure_enable,
  input wire logic time_measure_mode,
  input wire logic phase_measure_mode,
  input wire logic ext_mode,
  input wire logic reduced_power_tx_enable,
  input wire logic [7:0] phase_value,
  input wire logic sleep_tx_trigger_pin,
  input wire logic tx_frame_done,
  // Watched outputs
  input wire logic gain_loop_frozen_q,
  input wire logic auto_gain_off_q,
  input wire logic [3:0] tx_power_level_q,
  input wire logic pa_buf_en_q,
  input wire logic pa_en_q,
  input wire logic modulate_q,
  input wire logic [2:0] state_control_reg_q
);
  timeunit 1ns;
  timeprecision 1ps;
  logic pin_last_q;
  logic pin_go_q;
  logic pin_go_d;
  logic [12:0] gap_q;
  logic [12:0] gap_d;
  logic start_pin;
  logic rpc_live;
  // Reduced-power readback replaces the written code, so such writes are not judged here
  assign rpc_live = ext_mode && reduced_power_tx_enable;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  // Cycles since a pin start; command starts take as many cycles but are not tracked, so they are excluded
  always_comb begin
    start_pin = sleep_tx_trigger_pin && !pin_last_q && state_control_reg_q inside {3'd1, 3'd2};
    gap_d = (gap_q == 13'h1fff) ? gap_q : gap_q + 13'h0001;
    pin_go_d = pin_go_q;
    if (start_pin) begin
      gap_d = 13'h0001;
      pin_go_d = 1'b1;
    end else if (reg_wr && reg_addr == 6'h02) begin
      pin_go_d = 1'b0;
    end
  end
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      pin_last_q <= 1'b0;
      pin_go_q <= 1'b0;
      gap_q <= 13'h0000;
    end else begin
      pin_last_q <= sleep_tx_trigger_pin;
      pin_go_q <= pin_go_d;
      gap_q <= gap_d;
    end
  end
  sequence s_pin_rise;
    sleep_tx_trigger_pin && !$past(sleep_tx_trigger_pin);
  endsequence
  sequence s_idle_rise;
    state_control_reg_q == 3'd1 ##0 s_pin_rise;
  endsequence
  a_pin_to_busy: assert property (s_idle_rise |=> state_control_reg_q == 3'd3 && pa_buf_en_q && !pa_en_q)
    else $error("pin rise in idle did not start the buffer and busy state");
  a_off_refuses: assert property (state_control_reg_q == 3'd0 && !reg_wr ##0 s_pin_rise |=> state_control_reg_q == 3'd0)
    else $error("pin rise while off changed state");
  a_buffer_first: assert property (pa_en_q |-> pa_buf_en_q && $past(pa_buf_en_q))
    else $error("amplifier on without buffer on a cycle earlier");
  a_mod_delay: assert property ($rose(modulate_q) && pin_go_q |-> gap_q == 13'd4000)
    else $error("modulation did not start 4000 cycles after the pin edge");
  // The power output is registered from the programmed code, so it shows two edges on
  a_power_write: assert property (reg_wr && reg_addr == 6'h05 && !tx_frame_done && !rpc_live
    ##1 !(reg_wr && reg_addr == 6'h05) && !rpc_live
    |=> tx_power_level_q == $past(reg_wdata[3:0], 2))
    else $error("power code not taken from the write");
  a_power_rsvd: assert property (reg_rd && reg_addr == 6'h05 |=> reg_rdata_q[7:4] == 4'h0)
    else $error("power register upper bits not zero");
  a_phase_read: assert property (reg_rd && reg_addr == 6'h3b && phase_measure_mode |=> reg_rdata_q == $past(phase_value))
    else $error("phase value not returned");
  a_align_read: assert property (reg_rd && reg_addr == 6'h3b && time_measure_mode && !phase_measure_mode |=> reg_rdata_q[7:4] == 4'h0)
    else $error("alignment read upper bits not zero");
  a_test_gate: assert property (auto_gain_off_q || gain_loop_frozen_q |-> $past(phase_measure_enable) || $past(phase_measure_enable, 2))
    else $error("gain test field acted without phase enable");
endmodule : rgt_gain_power_chk
bind rgt_gain_power rgt_gain_power_chk u_chk (.*);
`default_nettype wire

/* File: tb/rgt_host.sv */
// Host model driving the serial register port
`default_nettype none
module rgt_host (
  // Clock
  input wire logic mclk,
  // Register port
  output logic [5:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [7:0] reg_rdata_q
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    reg_addr = 6'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // Data line is not held after a write, so it flips to expose stale use
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(negedge mclk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge mclk);
    reg_wr = 1'b0;
    reg_wdata = ~d;
  endtask : wr
  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    @(negedge mclk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge mclk);
    reg_rd = 1'b0;
    d = reg_rdata_q;
  endtask : rd
endmodule : rgt_host
`default_nettype wire

/* File: tb/rgt_gain_power_tb.sv */
// Self-checking bench for the gain and transmit power block
`default_nettype none
module rgt_gain_power_tb
  import rgt_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic pme = 1'b0, tmm = 1'b0, pmm = 1'b0, ext = 1'b0, rpe = 1'b0;
  logic [7:0] phv = 8'h00;
  logic [3:0] reduced_power_control = 4'h0;
  logic [1:0] agt = 2'h1;
  logic pin = 1'b0, fdone = 1'b0;
  logic [1:0] gain;
  logic frz, aoff, pbuf, paen, modq, cko;
  logic [3:0] pwr;
  logic [2:0] st;
  logic [7:0] rv;
  int error_cnt = 0;
  int n_compared = 0;
  logic [5:0] bus_addr;
  logic [7:0] bus_wdata;
  logic [7:0] bus_rdata;
  logic bus_wr;
  logic bus_rd;
  rgt_host u_host (.mclk(mclk), .reg_addr(bus_addr), .reg_wdata(bus_wdata), .reg_wr(bus_wr),
    .reg_rd(bus_rd), .reg_rdata_q(bus_rdata));
  rgt_gain_power DUT (.mclk(mclk), .rst_b(rst_b), .reg_addr(bus_addr),
    .reg_wdata(bus_wdata), .reg_wr(bus_wr), .reg_rd(bus_rd),
    .reg_rdata_q(bus_rdata), .phase_measure_enable(pme), .time_measure_mode(tmm),
    .phase_measure_mode(pmm), .ext_mode(ext), .reduced_power_tx_enable(rpe),
    .phase_value(phv), .rpc_power_level(reduced_power_control), .auto_gain_target(agt),
    .sleep_tx_trigger_pin(pin), .tx_frame_done(fdone), .rx_gain_q(gain),
    .gain_loop_frozen_q(frz), .auto_gain_off_q(aoff), .tx_power_level_q(pwr),
    .pa_buf_en_q(pbuf), .pa_en_q(paen), .modulate_q(modq), .state_control_reg_q(st),
    .clock_output_pin_q(cko));
  initial begin
    forever #2 mclk = ~mclk;
  end
  task automatic chk(input string nm, input logic [12:0] seen, input logic [12:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask : cyc
  task automatic wrap_up();
    if (error_cnt == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : wrap_up
  task automatic t_reset();
    chk("gain", gain, 0);
    chk("power", pwr, 0);
    u_host.rd(6'h05, rv);
    chk("pwr reg", rv, 0);
    u_host.rd(6'h3b, rv);
    chk("time reg", rv, 0);
  endtask : t_reset
  task automatic t_power();
    u_host.wr(6'h05, 8'hff);
    u_host.rd(6'h05, rv);
    chk("pwr rsvd", rv, 8'h0f);
    chk("power", pwr, 4'hf);
    u_host.wr(6'h05, 8'h07);
  endtask : t_power
  task automatic t_gain();
    u_host.wr(6'h3c, 8'h0a);
    cyc(2);
    chk("auto off gated", aoff, 0);
    chk("auto gain", gain, 1);
    u_host.rd(6'h3c, rv);
    chk("test reg", rv, 8'h0a);
    pme = 1'b1;
    cyc(2);
    chk("auto off", aoff, 1);
    chk("manual gain", gain, 2);
    for (int g = 0; g < 3; g++) begin
      u_host.wr(6'h3c, 8'h08 | g[7:0]);
      cyc(2);
      chk("gain code", gain, g[12:0]);
    end
    u_host.wr(6'h3c, 8'h04);
    cyc(2);
    chk("freeze no sel", frz, 0);
    u_host.wr(6'h3c, 8'h24);
    cyc(2);
    chk("freeze", frz, 1);
    agt = 2'h2;
    cyc(2);
    chk("frozen gain", gain, 1);
    u_host.wr(6'h3c, 8'h20);
    cyc(2);
    chk("free run", frz, 0);
    chk("free gain", gain, 2);
    u_host.wr(6'h3c, 8'h10);
    cyc(2);
    chk("loop reset", gain, 0);
    pme = 1'b0;
  endtask : t_gain
  task automatic t_tx();
    int k;
    u_host.wr(6'h02, 8'h09);
    cyc(1);
    chk("pll idle", st, 1);
    @(posedge cko);
    cyc(126);
    chk("clock out low", cko, 0);
    // Pin edge lands 100.5 cycles (402 ns) after a clock output rise: step 6
    @(posedge cko);
    cyc(101);
    pin = 1'b1;
    cyc(2);
    chk("busy", st, 3);
    chk("buf only", {pbuf, paen}, 2'b10);
    // Two cycles have already passed since the pin edge
    k = 2;
    while (!modq && k < 5000) begin
      cyc(1);
      k++;
    end
    chk("mod delay", k[12:0], 13'd4000);
    tmm = 1'b1;
    u_host.rd(6'h3b, rv);
    chk("align", rv, 8'h06);
    ext = 1'b1;
    rpe = 1'b1;
    u_host.rd(6'h05, rv);
    chk("pwr before frame", rv, 8'h07);
    reduced_power_control = 4'h9;
    fdone = 1'b1;
    cyc(1);
    fdone = 1'b0;
    pin = 1'b0;
    cyc(1);
    chk("back idle", {st, pbuf, paen, modq}, {3'd1, 3'b000});
    u_host.rd(6'h05, rv);
    chk("used power", rv, 8'h09);
    u_host.wr(6'h02, 8'h09);
    u_host.rd(6'h05, rv);
    chk("restored", rv, 8'h07);
    u_host.wr(6'h02, 8'h19);
    u_host.wr(6'h02, 8'h02);
    cyc(1);
    chk("cmd start", {st, pbuf}, {3'd4, 1'b1});
    fdone = 1'b1;
    cyc(1);
    fdone = 1'b0;
    cyc(1);
    chk("retry ready", st, 2);
    u_host.wr(6'h02, 8'h08);
    pin = 1'b1;
    cyc(3);
    chk("off refuses", {st, pbuf}, 4'h0);
    pin = 1'b0;
  endtask : t_tx
  task automatic t_time();
    tmm = 1'b1;
    u_host.rd(6'h3b, rv);
    chk("align rsvd", rv & 8'hf0, 0);
    pmm = 1'b1;
    phv = 8'ha5;
    u_host.rd(6'h3b, rv);
    chk("phase", rv, 8'ha5);
  endtask : t_time
  initial begin
    repeat (3) @(negedge mclk);
    rst_b = 1'b1;
    cyc(1);
    t_reset();
    t_power();
    t_gain();
    t_tx();
    t_time();
    wrap_up();
  end
  // Whole run needs about 4600 cycles; allow ample margin
  initial begin
    #100us;
    error_cnt++;
    wrap_up();
  end
endmodule : rgt_gain_power_tb
`default_nettype wire
